/* include/mfc_pkg.sv */
// shared constants and types for the multi function counter block
package mfc_pkg;
    // counter width and limits
    localparam int CNT_W = 32;
    localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    // clock rate and fastest tick
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MIN_NS = 25;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // a 25 ns tick cannot be finer than one 100 ns clock: one cycle
    localparam int TICK_MIN_CYC = (TICK_MIN_NS / CLK_NS) < 1 ? 1 :
        (TICK_MIN_NS / CLK_NS);
    localparam int DIV_W = 16;
    // second counter stop count for logging
    localparam logic [31:0] LOG_STOP_CNT = 32'h0000_03E8;
    // edge selection bit positions
    localparam int EDGE_RISE = 0;
    localparam int EDGE_FALL = 1;
    // compare modes
    typedef enum logic [1:0] {
        MFC_CMP_EQ = 2'b00,
        MFC_CMP_RANGE = 2'b01,
        MFC_CMP_OFF = 2'b11
    } mfc_cmp_t;
    // run state of a counter
    typedef enum logic [1:0] {
        MFC_IDLE = 2'b00,
        MFC_RUN = 2'b01
    } mfc_state_t;
endpackage : mfc_pkg

/* verif/mfc_top_tb.sv */
// self-checking bench for the multi function counter block
`timescale 1ns/1ns
`default_nettype none
module mfc_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pulse_i = 1'b0;
    logic start_i = 1'b0;
    logic [1:0] cnt_edge_i = 2'b11;
    logic ring_i = 1'b0;
    logic step_en_i = 1'b0;
    logic [31:0] step_i = 32'h0000_0001;
    logic [31:0] upper_i = mfc_pkg::CNT_MAX;
    logic [31:0] lower_i = 32'h0000_0000;
    logic [31:0] preset_i = 32'h0000_0000;
    logic halt_reload_i = 1'b1;
    logic [15:0] tick_div_i = 16'h0000;
    logic [1:0] cmp_mode_i = 2'b00;
    logic [31:0] cmp_a_i = 32'h0000_0001;
    logic [31:0] cmp_b_i = 32'h0000_0001;
    logic [1:0] func_i = 2'b01;
    logic meas_off_i = 1'b0;
    logic [31:0] shot_cmp_i = 32'h0000_0002;
    logic [31:0] shot_preset_i = 32'h0000_0000;
    logic [31:0] shot_step_i = 32'h0000_0001;
    logic shot_step_en_i = 1'b0;
    logic [15:0] shot_div_i = 16'h0000;
    logic [31:0] count_o, width_o, samples_o;
    logic cmp_o, ratio_o, strobe_o, busy_o;
    logic [31:0] s_rises, s_width, s_gap, r_rises, r_width, c_rises;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    // small stop count keeps the logging run short
    mfc_top #(.STOP_CNT(32'h0000_0005)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .pulse_i(pulse_i), .start_i(start_i), .cnt_edge_i(cnt_edge_i),
        .ring_i(ring_i), .step_en_i(step_en_i), .step_i(step_i),
        .upper_i(upper_i), .lower_i(lower_i), .preset_i(preset_i),
        .halt_reload_i(halt_reload_i), .tick_div_i(tick_div_i),
        .cmp_mode_i(cmp_mode_i), .cmp_a_i(cmp_a_i), .cmp_b_i(cmp_b_i),
        .func_i(func_i), .meas_off_i(meas_off_i), .shot_cmp_i(shot_cmp_i),
        .shot_preset_i(shot_preset_i), .shot_step_i(shot_step_i),
        .shot_step_en_i(shot_step_en_i), .shot_div_i(shot_div_i),
        .count_o(count_o), .width_o(width_o), .cmp_o(cmp_o),
        .ratio_o(ratio_o), .strobe_o(strobe_o), .busy_o(busy_o),
        .samples_o(samples_o));

    // far-side watchers on strobe, one-shot and compare outputs
    mfc_watch u_strobe (.clk_i(clk_i), .rst_i(rst_i), .sig_i(strobe_o),
        .rises_o(s_rises), .width_o(s_width), .gap_o(s_gap));
    mfc_watch u_ratio (.clk_i(clk_i), .rst_i(rst_i), .sig_i(ratio_o),
        .rises_o(r_rises), .width_o(r_width), .gap_o());
    mfc_watch u_cmp (.clk_i(clk_i), .rst_i(rst_i), .sig_i(cmp_o),
        .rises_o(c_rises), .width_o(), .gap_o());

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // reset also clears the watchers
    task automatic do_reset();
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(2);
    endtask : do_reset

    task automatic pulse(input int hi, input int lo);
        pulse_i <= 1'b1;
        tick(hi);
        pulse_i <= 1'b0;
        tick(lo);
    endtask : pulse

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // hang guard, well above the about 1700 cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        // on and off width, linear count up to all ones, every clock
        do_reset();
        tick(3);
        pulse(37, 10);
        chk("on width", {31'h0, width_o >= 36 && width_o <= 37}, 1);
        chk("preset after halt", count_o, 32'h0000_0000);
        chk("busy after halt", {31'h0, busy_o}, 0);
        pulse(12, 10);
        chk("new width", {31'h0, width_o >= 11 && width_o <= 12}, 1);
        meas_off_i <= 1'b1;
        pulse(5, 25);
        pulse(5, 5);
        chk("off width", {31'h0, width_o >= 24 && width_o <= 25}, 1);
        $display("test measure done");
        // logging: 1 us tick, ring 1..20, stops after five strobes
        func_i <= 2'b10;
        ring_i <= 1'b1;
        upper_i <= 32'h0000_0015;
        lower_i <= 32'h0000_0001;
        tick_div_i <= 16'h0009;
        meas_off_i <= 1'b0;
        do_reset();
        start_i <= 1'b1;
        tick(2);
        start_i <= 1'b0;
        tick(50);
        chk("busy while logging", {31'h0, busy_o}, 1);
        // the last strobe is cut by the halt, so judge the first one
        chk("strobe width", s_width, 32'h0000_000A);
        tick(1200);
        chk("strobe count", s_rises, 32'h0000_0005);
        chk("strobe spacing", s_gap, 32'h0000_00C8);
        chk("sample count", samples_o, 32'h0000_0005);
        chk("logging halted", {31'h0, busy_o}, 0);
        chk("count preset", count_o, 32'h0000_0000);
        $display("test logging done");
        // ratio 3/10: step 3 over half of 20, rising edges only first
        func_i <= 2'b00;
        upper_i <= 32'h0000_0014;
        lower_i <= 32'h0000_0000;
        step_i <= 32'h0000_0003;
        step_en_i <= 1'b1;
        tick_div_i <= 16'h0000;
        cnt_edge_i <= 2'b01;
        do_reset();
        repeat (2) pulse(6, 6);
        chk("rise only count", count_o, 32'h0000_0006);
        cnt_edge_i <= 2'b11;
        do_reset();
        repeat (2) pulse(6, 6);
        chk("both edge count", count_o, 32'h0000_000C);
        repeat (8) pulse(6, 6);
        tick(20);
        chk("compare rises", c_rises, 32'h0000_0003);
        // twenty steps of 3 over a span of 20 land back on zero
        chk("ring remainder", count_o, 32'h0000_0000);
        chk("ratio pulses", r_rises, 32'h0000_0003);
        chk("shot width", r_width, 32'h0000_0003);
        // step mode: (5 - 0 + 1) / 3 ticks
        shot_cmp_i <= 32'h0000_0005;
        shot_step_i <= 32'h0000_0003;
        shot_step_en_i <= 1'b1;
        do_reset();
        repeat (10) pulse(6, 6);
        tick(20);
        chk("step ratio pulses", r_rises, 32'h0000_0003);
        chk("step shot width", r_width, 32'h0000_0002);
        $display("test ratio done");
        close_out();
    end
endmodule : mfc_top_tb
`default_nettype wire

/* verif/mfc_watch.sv */
// sampling equipment model: counts rises, high width and rise spacing
`timescale 1ns/1ns
`default_nettype none
module mfc_watch (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched output
    input wire logic sig_i,
    // measurements
    output logic [31:0] rises_o,
    output logic [31:0] width_o,
    output logic [31:0] gap_o
);
    logic prev;
    logic [31:0] run;
    logic [31:0] since;
    // rise count and spacing are taken on each rising edge of the watched signal, the high width on each falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
            rises_o <= 32'h0000_0000;
            width_o <= 32'h0000_0000;
            gap_o <= 32'h0000_0000;
            run <= 32'h0000_0000;
            since <= 32'h0000_0000;
        end else begin
            prev <= sig_i;
            since <= since + 32'h0000_0001;
            if (sig_i && !prev) begin
                rises_o <= rises_o + 32'h0000_0001;
                gap_o <= since;
                since <= 32'h0000_0001;
            end
            if (sig_i) begin
                run <= prev ? run + 32'h0000_0001 : 32'h0000_0001;
            end
            if (!sig_i && prev) begin
                width_o <= run;
            end
        end
    end
endmodule : mfc_watch
`default_nettype wire

/* verilog/mfc_ctr.sv */
// counter timer with tick divider, ring wrap or linear stop, compare and capture
`timescale 1ns/1ns
`default_nettype none
module mfc_ctr #(
    parameter int W = mfc_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration, static while counting
    input wire logic ring_i,
    input wire logic step_en_i,
    input wire logic [W-1:0] step_i,
    input wire logic [W-1:0] upper_i,
    input wire logic [W-1:0] lower_i,
    input wire logic [W-1:0] preset_i,
    input wire logic halt_reload_i,
    input wire logic [mfc_pkg::DIV_W-1:0] tick_div_i,
    input wire logic [1:0] cmp_mode_i,
    input wire logic [W-1:0] cmp_a_i,
    input wire logic [W-1:0] cmp_b_i,
    // event inputs, one-cycle pulses, and the tick mode level
    input wire logic run_i,
    input wire logic halt_i,
    input wire logic cap_i,
    input wire logic count_i,
    input wire logic tick_mode_i,
    // results
    output logic [W-1:0] count_o,
    output logic [W-1:0] cap_o,
    output logic cmp_o,
    output logic running_o
);
    logic [mfc_pkg::DIV_W-1:0] div;
    logic tick;
    logic adv;
    logic [W:0] sum;

    // tick divider; divider 0 gives one tick per clock, the 100 ns floor
    always_ff @(posedge clk_i) begin
        if (rst_i || !running_o || div >= tick_div_i) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign tick = running_o && (div >= tick_div_i);

    // advance on tick in timer mode, on event pulse in counting mode
    assign adv = tick_mode_i ? tick : (running_o && count_i);
    assign sum = {1'b0, count_o} + {1'b0, (step_en_i ? step_i :
        W'(mfc_pkg::CNT_ONE))};

    // run / halt control
    always_ff @(posedge clk_i) begin
        if (rst_i || halt_i) begin
            running_o <= 1'b0;
        end else if (run_i) begin
            running_o <= 1'b1;
        end
    end

    // count register: halt reload wins over advance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (halt_i && halt_reload_i) begin
            count_o <= preset_i;
        end else if (adv) begin
            if (sum >= {1'b0, upper_i}) begin
                // ring carries the overshoot past the lower limit, so a
                // step that does not divide the span keeps the ratio exact;
                // linear stops at upper
                count_o <= ring_i ? lower_i + (sum[W-1:0] - upper_i)
                    : upper_i;
            end else begin
                count_o <= sum[W-1:0];
            end
        end
    end

    // capture holds the count at the capture edge, even with halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_o <= '0;
        end else if (cap_i) begin
            cap_o <= count_o;
        end
    end

    // comparator registered from the count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_o <= 1'b0;
        end else begin
            unique case (cmp_mode_i)
                mfc_pkg::MFC_CMP_EQ: cmp_o <= (count_o == cmp_a_i);
                mfc_pkg::MFC_CMP_RANGE: cmp_o <= (count_o >= cmp_a_i) &&
                    (count_o <= cmp_b_i);
                default: cmp_o <= 1'b0;
            endcase
        end
    end

    a_cap_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        cap_i |=> cap_o == $past(count_o))
        else $error("capture did not copy count");
    a_halt_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_i |=> !running_o)
        else $error("halt did not stop counting");
    a_run_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_i && !halt_i) |=> running_o)
        else $error("run did not start counting");
    a_reload_val: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && halt_reload_i) |=> count_o == $past(preset_i))
        else $error("halt reload missing");
    a_range_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp_mode_i == mfc_pkg::MFC_CMP_RANGE && count_o < cmp_a_i)
        |=> !cmp_o)
        else $error("range output high below threshold");
    a_ring_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (adv && ring_i && !halt_i && sum >= {1'b0, upper_i})
        |=> count_o == $past(lower_i) + ($past(sum[W-1:0]) -
        $past(upper_i)))
        else $error("ring did not reload lower limit");
    c_wrap: cover property (@(posedge clk_i)
        adv && ring_i && sum >= {1'b0, upper_i});
    c_cap: cover property (@(posedge clk_i) cap_i && halt_i);
endmodule : mfc_ctr
`default_nettype wire

/* verilog/mfc_edge.sv */
// edge detector giving a single clock pulse per selected edge
`timescale 1ns/1ns
`default_nettype none
module mfc_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // signal and edge selection
    input wire logic sig_i,
    input wire logic [1:0] sel_i,
    // pulse out
    output logic pulse_o
);
    logic prev;

    // previous sample; both edges may be enabled together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
            pulse_o <= 1'b0;
        end else begin
            prev <= sig_i;
            pulse_o <= (sel_i[mfc_pkg::EDGE_RISE] & sig_i & ~prev) |
                       (sel_i[mfc_pkg::EDGE_FALL] & ~sig_i & prev);
        end
    end

    a_edge_single: assert property (@(posedge clk_i) disable iff (rst_i)
        pulse_o |=> !pulse_o || (sel_i == 2'b11))
        else $error("edge pulse held two cycles");
endmodule : mfc_edge
`default_nettype wire

/* verilog/mfc_top.sv */
// multi function counter block: ratio, pulse width and logging strobe
`timescale 1ns/1ns
`default_nettype none
module mfc_top #(
    parameter int W = mfc_pkg::CNT_W,
    parameter logic [31:0] STOP_CNT = mfc_pkg::LOG_STOP_CNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // external pulse inputs
    input wire logic pulse_i,
    input wire logic start_i,
    // first counter configuration
    input wire logic [1:0] cnt_edge_i,
    input wire logic ring_i,
    input wire logic step_en_i,
    input wire logic [W-1:0] step_i,
    input wire logic [W-1:0] upper_i,
    input wire logic [W-1:0] lower_i,
    input wire logic [W-1:0] preset_i,
    input wire logic halt_reload_i,
    input wire logic [mfc_pkg::DIV_W-1:0] tick_div_i,
    input wire logic [1:0] cmp_mode_i,
    input wire logic [W-1:0] cmp_a_i,
    input wire logic [W-1:0] cmp_b_i,
    // function select
    input wire logic [1:0] func_i,
    input wire logic meas_off_i,
    // second stage one-shot configuration
    input wire logic [W-1:0] shot_cmp_i,
    input wire logic [W-1:0] shot_preset_i,
    input wire logic [W-1:0] shot_step_i,
    input wire logic shot_step_en_i,
    input wire logic [mfc_pkg::DIV_W-1:0] shot_div_i,
    // results
    output logic [W-1:0] count_o,
    output logic [W-1:0] width_o,
    output logic cmp_o,
    output logic ratio_o,
    output logic strobe_o,
    output logic busy_o,
    output logic [W-1:0] samples_o
);
    // function codes
    localparam logic [1:0] FN_RATIO = 2'b00;
    localparam logic [1:0] FN_MEAS = 2'b01;
    localparam logic [1:0] FN_LOG = 2'b10;

    logic cnt_ev, rise_ev, fall_ev, start_ev;
    logic run0, halt0, cap0, count0, tmode0;
    logic [1:0] mode0;
    logic [W-1:0] a0, b0, up0, lo0, pre0;
    logic ring0, rld0;
    logic [W-1:0] c0_count, c0_cap;
    logic c0_cmp, c0_run;
    logic cmp_prev, cmp_rise;
    logic shot_run, shot_done;
    logic [W-1:0] shot_count;
    logic [W:0] shot_sum;
    logic [mfc_pkg::DIV_W-1:0] shot_div;
    logic shot_tick;
    logic [W-1:0] log_count;
    logic log_halt;
    logic [mfc_pkg::DIV_W:0] strobe_len;

    // counting edge for ratio mode; both edges may be set
    mfc_edge u_cnt_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(pulse_i),
        .sel_i(cnt_edge_i),
        .pulse_o(cnt_ev)
    );
    // measurement edges
    mfc_edge u_rise (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(pulse_i),
        .sel_i(2'b01),
        .pulse_o(rise_ev)
    );
    mfc_edge u_fall (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(pulse_i),
        .sel_i(2'b10),
        .pulse_o(fall_ev)
    );
    // logging start edge
    mfc_edge u_start (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(start_i),
        .sel_i(2'b01),
        .pulse_o(start_ev)
    );

    // route events and settings to the first counter per function
    always_comb begin
        run0 = 1'b0;
        halt0 = 1'b0;
        cap0 = 1'b0;
        count0 = cnt_ev;
        tmode0 = 1'b1;
        mode0 = cmp_mode_i;
        a0 = cmp_a_i;
        b0 = cmp_b_i;
        up0 = upper_i;
        lo0 = lower_i;
        pre0 = preset_i;
        ring0 = ring_i;
        rld0 = halt_reload_i;
        unique case (func_i)
            FN_RATIO: begin
                // count on edges, ring mode, range compare
                run0 = !c0_run;
                tmode0 = 1'b0;
                ring0 = 1'b1;
                mode0 = mfc_pkg::MFC_CMP_RANGE;
                a0 = upper_i >> 1;
                b0 = upper_i - 1'b1;
            end
            FN_MEAS: begin
                // off width swaps the run and halt edges
                run0 = meas_off_i ? fall_ev : rise_ev;
                halt0 = meas_off_i ? rise_ev : fall_ev;
                cap0 = halt0;
                ring0 = 1'b0;
                up0 = W'(mfc_pkg::CNT_MAX);
                lo0 = '0;
                pre0 = '0;
                rld0 = 1'b1;
            end
            FN_LOG: begin
                // ring between limits, equal compare at the lower limit
                run0 = start_ev;
                halt0 = log_halt;
                ring0 = 1'b1;
                mode0 = mfc_pkg::MFC_CMP_EQ;
                a0 = lower_i;
                pre0 = '0;
                rld0 = 1'b1;
            end
            default: begin
                mode0 = mfc_pkg::MFC_CMP_OFF;
            end
        endcase
    end

    // the shared counter timer
    mfc_ctr #(.W(W)) u_ctr0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ring_i(ring0),
        .step_en_i(step_en_i),
        .step_i(step_i),
        .upper_i(up0),
        .lower_i(lo0),
        .preset_i(pre0),
        .halt_reload_i(rld0),
        .tick_div_i(tick_div_i),
        .cmp_mode_i(mode0),
        .cmp_a_i(a0),
        .cmp_b_i(b0),
        .run_i(run0),
        .halt_i(halt0),
        .cap_i(cap0),
        .count_i(count0),
        .tick_mode_i(tmode0),
        .count_o(c0_count),
        .cap_o(c0_cap),
        .cmp_o(c0_cmp),
        .running_o(c0_run)
    );

    // rising edge of the compare output is the event link
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_prev <= 1'b0;
        end else begin
            cmp_prev <= c0_cmp;
        end
    end
    assign cmp_rise = c0_cmp && !cmp_prev;

    // one-shot tick divider
    always_ff @(posedge clk_i) begin
        if (rst_i || !shot_run || shot_div >= shot_div_i) begin
            shot_div <= '0;
        end else begin
            shot_div <= shot_div + 1'b1;
        end
    end
    assign shot_tick = shot_run && (shot_div >= shot_div_i);
    assign shot_sum = {1'b0, shot_count} + {1'b0, (shot_step_en_i ?
        shot_step_i : W'(mfc_pkg::CNT_ONE))};
    // high from preset through compare: (compare-preset+1)/step ticks, rounded up
    assign shot_done = shot_tick && (shot_sum > {1'b0, shot_cmp_i});

    // one-shot state: set on compare rise in ratio function, clear after its time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shot_run <= 1'b0;
            shot_count <= '0;
        end else if (func_i == FN_RATIO && cmp_rise && !shot_run) begin
            shot_run <= 1'b1;
            shot_count <= shot_preset_i;
        end else if (shot_done) begin
            shot_run <= 1'b0;
        end else if (shot_tick) begin
            shot_count <= shot_sum[W-1:0];
        end
    end

    // second counter: counts strobes, halts the first at the stop count
    always_ff @(posedge clk_i) begin
        if (rst_i || (func_i == FN_LOG && start_ev && !c0_run)) begin
            log_count <= '0;
        end else if (func_i == FN_LOG && cmp_rise && c0_run) begin
            log_count <= log_count + 1'b1;
        end
    end
    assign log_halt = c0_run && (log_count == STOP_CNT);

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
            width_o <= '0;
            cmp_o <= 1'b0;
            ratio_o <= 1'b0;
            strobe_o <= 1'b0;
            busy_o <= 1'b0;
            samples_o <= '0;
        end else begin
            count_o <= c0_count;
            width_o <= c0_cap;
            cmp_o <= c0_cmp;
            ratio_o <= shot_run;
            strobe_o <= func_i == FN_LOG && c0_cmp && c0_run;
            busy_o <= c0_run;
            samples_o <= log_count;
        end
    end

    a_stop_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (func_i == FN_LOG && log_count == STOP_CNT && c0_run)
        |=> !c0_run)
        else $error("logging did not stop at count");
    // clocks the strobe has stood so far; a tick spans tick_div_i+1
    // clocks, so a strobe may stand that long and no longer
    always_ff @(posedge clk_i) begin
        if (rst_i || !strobe_o) begin
            strobe_len <= '0;
        end else begin
            strobe_len <= strobe_len + 1'b1;
        end
    end

    a_strobe_once: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_o |-> strobe_len <= {1'b0, tick_div_i})
        else $error("strobe longer than one tick");
    c_ratio_pulse: cover property (@(posedge clk_i) $rose(ratio_o));
    c_log_end: cover property (@(posedge clk_i) log_halt);
    c_meas: cover property (@(posedge clk_i) func_i == FN_MEAS && cap0);
endmodule : mfc_top
`default_nettype wire
